// [core/pscc_consts.svh]
`ifndef PSCC_CONSTS_SVH
`define PSCC_CONSTS_SVH
// Command codes
`define PSCC_CMD_ON_OFF       8'h01
`define PSCC_CMD_CLEAR_FAULTS 8'h03
`define PSCC_CMD_WRITE_LOCK   8'h10
`define PSCC_CMD_STORE_DEFLT  8'h11
`define PSCC_CMD_VOUT_SET     8'h21
`define PSCC_CMD_OV_WARN_LVL  8'h42
`define PSCC_CMD_OC_REACT     8'h47
`define PSCC_CMD_OT_REACT     8'h50
`define PSCC_CMD_SUM_BYTE     8'h78
`define PSCC_CMD_SUM_WORD     8'h79
`define PSCC_CMD_VOUT_STAT    8'h7A
`define PSCC_CMD_IOUT_STAT    8'h7B
`define PSCC_CMD_INPUT_STAT   8'h7C
`define PSCC_CMD_TEMP_STAT    8'h7D
`define PSCC_CMD_MAKER_STAT   8'h80
`define PSCC_CMD_FAN_STAT     8'h81
// Data values
`define PSCC_UNIT_ON          8'h80
`define PSCC_UNIT_OFF         8'h00
`define PSCC_WL_OPEN          8'h00
`define PSCC_WL_LOCK_A        8'h80
`define PSCC_WL_LOCK_B        8'h40
`define PSCC_REACT_HICCUP     8'hF8
`define PSCC_REACT_LATCH      8'hC0
// Reset values
`define PSCC_WL_RESET         8'h80
`define PSCC_VOUT_SET_RESET   16'h0000
`define PSCC_OV_WARN_RESET    16'hFFFF
// Positions in the fault condition vector
`define PSCC_C_VOUT_OVF  0
`define PSCC_C_VOUT_UVW  1
`define PSCC_C_VOUT_UVF  2
`define PSCC_C_OCF       3
`define PSCC_C_OCW       4
`define PSCC_C_VIN_OVF   5
`define PSCC_C_VIN_OVW   6
`define PSCC_C_VIN_UVW   7
`define PSCC_C_VIN_UVF   8
`define PSCC_C_OTF       9
`define PSCC_C_OTW       10
`define PSCC_C_FAN1F     11
`define PSCC_C_FAN2F     12
`define PSCC_C_FAN1OVR   13
`define PSCC_C_FAN2OVR   14
`define PSCC_C_AUXF      15
`define PSCC_C_NVM_BUSY  16
`define PSCC_C_WIDTH     17
`endif

// [core/pscc_pkg.sv]
`default_nettype none
package pscc_pkg;
  typedef enum logic [2:0] {
    PSCC_ST_IDLE = 3'b001,
    PSCC_ST_EXEC = 3'b010,
    PSCC_ST_ANSWER = 3'b100
  } pscc_state_t;
endpackage : pscc_pkg
`default_nettype wire

// [core/pscc_handler.sv]
// Overview of operation
// RQ1 - Summary byte: busy, off, OV, OC, UV, temp, comm, other
// RQ2 - Word high byte: vout, iout, input, maker, off, fan, other
// RQ3 - Word low byte equals the summary byte
// RQ4 - Fan status: faults bits 7,6; overrides 3,2
// RQ5 - Output on after reset when remote pin high
// RQ6 - On/off command: 80 on, 00 off
// RQ7 - Host resets unit by off, wait, on
// RQ8 - Restart clears all alarms and shutdowns
// RQ9 - Clear faults empties status, releases alert
// RQ10 - Persisting fault re-sets status and alert
// RQ11 - Reads always allowed regardless of write lock
// RQ12 - Lock 00 open; 80 or 40 lock others
// RQ13 - Write lock resets to 80
// RQ14 - Store defaults saves write lock setting
// RQ15 - Setpoint command sets output voltage
// RQ16 - Host should change setpoints by broadcast
// RQ17 - Bus setpoint overrides programming pin until controller reset
// RQ18 - Controller reset returns to pin setpoint
// RQ19 - OC and OT reactions default hiccup
// RQ20 - Only latched and hiccup reactions accepted
// RQ21 - Host recovers latch by cycling remote pin
// RQ22 - Output overvoltage warning at programmed level
// RQ23 - Bad command or data sets comm flag
// RQ24 - Unsupported read returns zero
// RQ25 - Unused status bits read zero
`default_nettype none
`include "pscc_consts.svh"
module pscc_handler (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic link_clk,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [7:0] req_code,
  input wire logic [15:0] req_data,
  output logic req_ready,
  output logic rsp_valid,
  output logic [15:0] rsp_data,
  input wire logic remote_on,
  input wire logic [`PSCC_C_WIDTH-1:0] fault_cond,
  input wire logic [15:0] vprog_code,
  input wire logic [15:0] vout_meas,
  output logic pwr_en,
  output logic [15:0] vset_out,
  output logic alert_o,
  output logic alert_oe_n,
  output logic nvm_store,
  output logic [7:0] nvm_data
);
  import pscc_pkg::*;

  // Link domain reset and request capture
  logic lrst_s1, lrst_s2;
  logic req_tgl, ack_s1, ack_s2, ack_s3;
  logic l_write;
  logic [7:0] l_code;
  logic [15:0] l_data;
  logic [15:0] core_rdata;
  logic core_ack;

  always_ff @(posedge link_clk) begin
    lrst_s1 <= sys_rst;
    lrst_s2 <= lrst_s1;
  end

  // Fields stay frozen until the answer returns, so the core may sample them
  always_ff @(posedge link_clk) begin
    if (lrst_s2) begin
      req_tgl <= 1'b0;
      req_ready <= 1'b0;
      l_write <= 1'b0;
      l_code <= 8'h00;
      l_data <= 16'h0000;
      rsp_valid <= 1'b0;
      rsp_data <= 16'h0000;
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
      ack_s3 <= 1'b0;
    end else begin
      ack_s1 <= core_ack;
      ack_s2 <= ack_s1;
      ack_s3 <= ack_s2;
      rsp_valid <= 1'b0;
      if (req_valid && req_ready) begin
        l_write <= req_write;
        l_code <= req_code;
        l_data <= req_data;
        req_tgl <= ~req_tgl;
        req_ready <= 1'b0;
      end else if (ack_s2 != ack_s3) begin
        rsp_valid <= 1'b1;
        rsp_data <= core_rdata;
        req_ready <= 1'b1;
      end else if (ack_s2 == req_tgl && ack_s3 == req_tgl && !rsp_valid) begin
        req_ready <= 1'b1;
      end
    end
  end

  // Core domain synchronisers
  logic rq_s1, rq_s2, rq_s3;
  logic ron_s1, ron_s2, ron_s3;
  logic [`PSCC_C_WIDTH-1:0] fc_s1, fc;
  logic [15:0] vp_s1, vp;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rq_s1 <= 1'b0;
      rq_s2 <= 1'b0;
      rq_s3 <= 1'b0;
      ron_s1 <= 1'b0;
      ron_s2 <= 1'b0;
      ron_s3 <= 1'b0;
      fc_s1 <= '0;
      fc <= '0;
      vp_s1 <= 16'h0000;
      vp <= 16'h0000;
    end else begin
      rq_s1 <= req_tgl;
      rq_s2 <= rq_s1;
      rq_s3 <= rq_s2;
      ron_s1 <= remote_on;
      ron_s2 <= ron_s1;
      ron_s3 <= ron_s2;
      fc_s1 <= fault_cond;
      fc <= fc_s1;
      vp_s1 <= vprog_code;
      vp <= vp_s1;
    end
  end

  // Configuration and status state
  pscc_state_t state;
  logic unit_on, bus_set, bus_comm_fault_flag;
  logic [7:0] wlock, oc_react, ot_react;
  logic [15:0] vout_cmd, ov_warn_lvl;
  logic oc_latched, ot_latched;
  logic [7:0] vout_st, iout_st, in_st, temp_st, fan_st, mfr_st;
  logic [7:0] vout_lv, iout_lv, in_lv, temp_lv, fan_lv, mfr_lv;
  logic [7:0] sbyte;
  logic [15:0] sword;
  logic ov_warn, alert_any, shutdown, restart;
  logic exec, wr, wr_ok, known, bad_data, clr_faults;

  assign exec = (state == PSCC_ST_EXEC);
  assign wr = exec && l_write;
  // RQ12 lock decode
  assign wr_ok = (wlock == `PSCC_WL_OPEN) || (l_code == `PSCC_CMD_WRITE_LOCK);
  assign clr_faults = wr && (l_code == `PSCC_CMD_CLEAR_FAULTS);
  // RQ22 warning compare
  assign ov_warn = (vout_meas > ov_warn_lvl);
  // RQ25 unused bits tied low
  assign vout_lv = {fc[`PSCC_C_VOUT_OVF], ov_warn, fc[`PSCC_C_VOUT_UVW],
                    fc[`PSCC_C_VOUT_UVF], 4'h0};
  assign iout_lv = {fc[`PSCC_C_OCF], 1'b0, fc[`PSCC_C_OCW], 5'h00};
  assign in_lv = {fc[`PSCC_C_VIN_OVF], fc[`PSCC_C_VIN_OVW], fc[`PSCC_C_VIN_UVW],
                  fc[`PSCC_C_VIN_UVF], 4'h0};
  assign temp_lv = {fc[`PSCC_C_OTF], fc[`PSCC_C_OTW], 6'h00};
  // RQ4 fan bits
  assign fan_lv = {fc[`PSCC_C_FAN1F], fc[`PSCC_C_FAN2F], 2'b00,
                   fc[`PSCC_C_FAN1OVR], fc[`PSCC_C_FAN2OVR], 2'b00};
  assign mfr_lv = {fc[`PSCC_C_AUXF], 1'b0, alert_any,
                   fc[`PSCC_C_VOUT_OVF] | fc[`PSCC_C_OCF] | fc[`PSCC_C_OTF] |
                   fc[`PSCC_C_VIN_UVF] | fc[`PSCC_C_VIN_OVF] | fc[`PSCC_C_AUXF],
                   ~ron_s2, fc[`PSCC_C_VOUT_OVF] | fc[`PSCC_C_OCF],
                   fc[`PSCC_C_VIN_UVF] | fc[`PSCC_C_VIN_OVF], 1'b0};

  // RQ1 summary byte
  assign sbyte = {fc[`PSCC_C_NVM_BUSY], ~pwr_en, vout_st[7], iout_st[7], in_st[4],
                  |temp_st, bus_comm_fault_flag,
                  (|vout_st[6:4]) | iout_st[5] | (|in_st[7:5]) | (|fan_st) |
                  mfr_st[7]};
  // RQ2 word high byte; RQ3 low byte shared
  assign sword = {|vout_st, |iout_st, |in_st, |mfr_st, ~pwr_en, |fan_st, mfr_st[7], 1'b0,
                  sbyte};
  assign alert_any = bus_comm_fault_flag | (|vout_st) | (|iout_st) | (|in_st) | (|temp_st) | (|fan_st);

  // RQ8 restart on bus off-to-on or remote pin rise
  assign restart = (wr && wr_ok && l_code == `PSCC_CMD_ON_OFF &&
                    l_data[7:0] == `PSCC_UNIT_ON && !unit_on) || (ron_s2 && !ron_s3);

  always_comb begin
    known = 1'b1;
    bad_data = 1'b0;
    case (l_code)
      `PSCC_CMD_ON_OFF: bad_data = l_write && l_data[7:0] != `PSCC_UNIT_ON &&
                                   l_data[7:0] != `PSCC_UNIT_OFF;
      `PSCC_CMD_WRITE_LOCK: bad_data = l_write && l_data[7:0] != `PSCC_WL_OPEN &&
                                       l_data[7:0] != `PSCC_WL_LOCK_A &&
                                       l_data[7:0] != `PSCC_WL_LOCK_B;
      `PSCC_CMD_OC_REACT, `PSCC_CMD_OT_REACT: bad_data = l_write &&
          l_data[7:0] != `PSCC_REACT_HICCUP && l_data[7:0] != `PSCC_REACT_LATCH;
      `PSCC_CMD_CLEAR_FAULTS, `PSCC_CMD_STORE_DEFLT: known = l_write;
      `PSCC_CMD_VOUT_SET, `PSCC_CMD_OV_WARN_LVL: known = 1'b1;
      `PSCC_CMD_SUM_BYTE, `PSCC_CMD_SUM_WORD, `PSCC_CMD_VOUT_STAT, `PSCC_CMD_IOUT_STAT,
      `PSCC_CMD_INPUT_STAT, `PSCC_CMD_TEMP_STAT, `PSCC_CMD_MAKER_STAT,
      `PSCC_CMD_FAN_STAT: known = !l_write;
      default: known = 1'b0;
    endcase
  end

  // Command sequencer
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state <= PSCC_ST_IDLE;
      core_ack <= 1'b0;
    end else begin
      case (state)
        PSCC_ST_IDLE: if (rq_s2 != rq_s3) state <= PSCC_ST_EXEC;
        PSCC_ST_EXEC: state <= PSCC_ST_ANSWER;
        PSCC_ST_ANSWER: begin
          core_ack <= ~core_ack;
          state <= PSCC_ST_IDLE;
        end
        default: state <= PSCC_ST_IDLE;
      endcase
    end
  end

  // Read answers; held until the next command
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      core_rdata <= 16'h0000;
    end else if (exec) begin
      // RQ11 reads ignore lock
      case (l_code)
        `PSCC_CMD_ON_OFF: core_rdata <= {8'h00, unit_on ? `PSCC_UNIT_ON : `PSCC_UNIT_OFF};
        `PSCC_CMD_WRITE_LOCK: core_rdata <= {8'h00, wlock};
        `PSCC_CMD_VOUT_SET: core_rdata <= vout_cmd;
        `PSCC_CMD_OV_WARN_LVL: core_rdata <= ov_warn_lvl;
        `PSCC_CMD_OC_REACT: core_rdata <= {8'h00, oc_react};
        `PSCC_CMD_OT_REACT: core_rdata <= {8'h00, ot_react};
        `PSCC_CMD_SUM_BYTE: core_rdata <= {8'h00, sbyte};
        `PSCC_CMD_SUM_WORD: core_rdata <= sword;
        `PSCC_CMD_VOUT_STAT: core_rdata <= {8'h00, vout_st};
        `PSCC_CMD_IOUT_STAT: core_rdata <= {8'h00, iout_st};
        `PSCC_CMD_INPUT_STAT: core_rdata <= {8'h00, in_st};
        `PSCC_CMD_TEMP_STAT: core_rdata <= {8'h00, temp_st};
        `PSCC_CMD_MAKER_STAT: core_rdata <= {8'h00, mfr_st};
        `PSCC_CMD_FAN_STAT: core_rdata <= {8'h00, fan_st};
        // RQ24 unsupported reads zero
        default: core_rdata <= 16'h0000;
      endcase
    end
  end

  // Writable configuration
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      // RQ5 on by default
      unit_on <= 1'b1;
      // RQ13 lock default
      wlock <= `PSCC_WL_RESET;
      // RQ19 hiccup defaults
      oc_react <= `PSCC_REACT_HICCUP;
      ot_react <= `PSCC_REACT_HICCUP;
      vout_cmd <= `PSCC_VOUT_SET_RESET;
      ov_warn_lvl <= `PSCC_OV_WARN_RESET;
      // RQ18 back to pin control
      bus_set <= 1'b0;
    end else if (wr && wr_ok && !bad_data) begin
      case (l_code)
        // RQ6 on/off decode
        `PSCC_CMD_ON_OFF: unit_on <= (l_data[7:0] == `PSCC_UNIT_ON);
        `PSCC_CMD_WRITE_LOCK: wlock <= l_data[7:0];
        // RQ15 RQ17 setpoint takes over
        `PSCC_CMD_VOUT_SET: begin
          vout_cmd <= l_data;
          bus_set <= 1'b1;
        end
        `PSCC_CMD_OV_WARN_LVL: ov_warn_lvl <= l_data;
        // RQ20 only two reactions reach here
        `PSCC_CMD_OC_REACT: oc_react <= l_data[7:0];
        `PSCC_CMD_OT_REACT: ot_react <= l_data[7:0];
        default: unit_on <= unit_on;
      endcase
    end
  end

  // RQ14 store the lock setting
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      nvm_store <= 1'b0;
      nvm_data <= 8'h00;
    end else begin
      nvm_store <= wr && wr_ok && (l_code == `PSCC_CMD_STORE_DEFLT);
      if (wr && wr_ok && l_code == `PSCC_CMD_STORE_DEFLT) nvm_data <= wlock;
    end
  end

  // RQ23 comm fault on bad command, data or locked write
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      bus_comm_fault_flag <= 1'b0;
    end else if (exec && (!known || bad_data || (l_write && !wr_ok))) begin
      bus_comm_fault_flag <= 1'b1;
    end else if (clr_faults || restart) begin
      bus_comm_fault_flag <= 1'b0;
    end
  end

  // RQ9 RQ10 live faults win a clear; alert bit re-derives; RQ8 restart too
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      vout_st <= 8'h00;
      iout_st <= 8'h00;
      in_st <= 8'h00;
      temp_st <= 8'h00;
      fan_st <= 8'h00;
      mfr_st <= 8'h00;
    end else if ((clr_faults && wr_ok) || restart) begin
      vout_st <= vout_lv;
      iout_st <= iout_lv;
      in_st <= in_lv;
      temp_st <= temp_lv;
      fan_st <= fan_lv;
      mfr_st <= {mfr_lv[7:6], 1'b0, mfr_lv[4:0]};
    end else begin
      vout_st <= vout_st | vout_lv;
      iout_st <= iout_st | iout_lv;
      in_st <= in_st | in_lv;
      temp_st <= temp_st | temp_lv;
      fan_st <= fan_st | fan_lv;
      mfr_st <= mfr_st | mfr_lv;
    end
  end

  // RQ19 latched shutdowns; leaving latch mode also releases them
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      oc_latched <= 1'b0;
      ot_latched <= 1'b0;
    end else begin
      if (fc[`PSCC_C_OCF] && oc_react == `PSCC_REACT_LATCH) oc_latched <= 1'b1;
      else if (restart || oc_react != `PSCC_REACT_LATCH) oc_latched <= 1'b0;
      if (fc[`PSCC_C_OTF] && ot_react == `PSCC_REACT_LATCH) ot_latched <= 1'b1;
      else if (restart || ot_react != `PSCC_REACT_LATCH) ot_latched <= 1'b0;
    end
  end

  // Hiccup: output drops only while the fault is present
  assign shutdown = oc_latched | ot_latched | fc[`PSCC_C_OCF] | fc[`PSCC_C_OTF];

  // RQ5 RQ17 outputs; alert pin pulls low while comm flag or any status except the maker status is held
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pwr_en <= 1'b0;
      vset_out <= 16'h0000;
      alert_o <= 1'b0;
      alert_oe_n <= 1'b1;
    end else begin
      pwr_en <= unit_on && ron_s2 && !shutdown;
      vset_out <= bus_set ? vout_cmd : vp;
      alert_o <= 1'b0;
      alert_oe_n <= !alert_any;
    end
  end

  // Checks
  // RQ3 word low byte
  chk_word_low_byte: assert property (@(posedge ref_clk) disable iff (sys_rst) // RQ3
    (exec && !l_write && l_code == `PSCC_CMD_SUM_WORD) |=> core_rdata[7:0] == $past(sbyte))
    else $error("word low byte differs from summary byte");
  // RQ12 locked write ignored
  chk_lock_blocks_write: assert property (@(posedge ref_clk) disable iff (sys_rst) // RQ12
    (wr && wlock != `PSCC_WL_OPEN && l_code == `PSCC_CMD_VOUT_SET) |=> $stable(vout_cmd))
    else $error("setpoint changed while locked");
  // RQ10 persisting fault re-set
  chk_clear_rearm: assert property (@(posedge ref_clk) disable iff (sys_rst) // RQ10
    (clr_faults && wr_ok && fc[`PSCC_C_OCF]) |=> iout_st[7] ##1 !alert_oe_n)
    else $error("persisting fault lost by clear");
  // RQ8 restart clears
  chk_restart_clears: assert property (@(posedge ref_clk) disable iff (sys_rst) // RQ8
    (restart && !fc[`PSCC_C_OCF] && !fc[`PSCC_C_OCW]) |=> (iout_st == 8'h00 && !bus_comm_fault_flag))
    else $error("restart left alarms");
  // RQ23 bad command flagged
  chk_unsupported_cml: assert property (@(posedge ref_clk) disable iff (sys_rst) // RQ23
    (exec && !known) |=> bus_comm_fault_flag ##2 (sbyte[1] && !alert_oe_n)) else $error("comm fault missing");
  // RQ17 bus setpoint drives output
  chk_vset_override: assert property (@(posedge ref_clk) disable iff (sys_rst) // RQ17
    bus_set |=> (vset_out == $past(vout_cmd))) else $error("setpoint pin not overridden");
  // RQ19 latch keeps output off
  chk_latch_off: assert property (@(posedge ref_clk) disable iff (sys_rst) // RQ19
    (oc_latched && !restart && oc_react == `PSCC_REACT_LATCH) |=> (!pwr_en && oc_latched))
    else $error("latched output came on");
  // RQ6 off command
  chk_off_command: assert property (@(posedge ref_clk) disable iff (sys_rst) // RQ6
    (wr && wr_ok && l_code == `PSCC_CMD_ON_OFF && l_data[7:0] == `PSCC_UNIT_OFF)
    |=> !unit_on ##1 !pwr_en) else $error("off command ignored");
  // RQ24 unsupported read zero
  chk_unsup_read_zero: assert property (@(posedge ref_clk) disable iff (sys_rst) // RQ24
    (exec && !l_write && !known) |=> core_rdata == 16'h0000) else $error("nonzero answer");
  cov_clear_faults: cover property (@(posedge ref_clk) disable iff (sys_rst)
    clr_faults && wr_ok);
  cov_latch_restart: cover property (@(posedge ref_clk) disable iff (sys_rst)
    oc_latched ##1 restart);
  cov_link_answer: cover property (@(posedge link_clk) disable iff (lrst_s2) rsp_valid);
endmodule // pscc_handler
`default_nettype wire

// [tb/pscc_host_model.sv]
`default_nettype none
`include "pscc_consts.svh"
module pscc_host_model #(
  parameter int OFF_CYC = 20
) (
  output logic link_clk,
  output logic req_valid,
  output logic req_write,
  output logic [7:0] req_code,
  output logic [15:0] req_data,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_data
);
  timeunit 1ns;
  timeprecision 100ps;
  // Free running, the link side needs it for its reset sync
  initial begin
    link_clk = 1'b0;
    #3;
    forever #40 link_clk = ~link_clk;
  end
  initial begin
    req_valid = 1'b0;
    req_write = 1'b0;
    req_code = 8'h00;
    req_data = 16'h0000;
  end
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                      output logic [15:0] rd);
    do begin
      @(posedge link_clk);
      #1;
    end while (req_ready !== 1'b1);
    req_valid = 1'b1;
    req_write = w;
    req_code = c;
    req_data = d;
    @(posedge link_clk);
    #1;
    req_valid = 1'b0;
    // Released lines carry junk so a stale value cannot pass
    req_code = ~c;
    req_data = ~d;
    do begin
      @(posedge link_clk);
      #1;
    end while (rsp_valid !== 1'b1);
    rd = rsp_data;
  endtask
  task automatic off_on();
    logic [15:0] d;
    xfer(1'b1, `PSCC_CMD_ON_OFF, {8'h00, `PSCC_UNIT_OFF}, d);
    repeat (OFF_CYC) @(posedge link_clk);
    xfer(1'b1, `PSCC_CMD_ON_OFF, {8'h00, `PSCC_UNIT_ON}, d);
  endtask
endmodule // pscc_host_model
`default_nettype wire

// [tb/pscc_handler_tb_top.sv]
`default_nettype none
`include "pscc_consts.svh"
module pscc_handler_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk, sys_rst, link_clk, req_valid, req_write, req_ready, rsp_valid;
  logic remote_on, pwr_en, alert_o, alert_oe_n, nvm_store;
  logic [7:0] req_code, nvm_data, nvm_last;
  logic [15:0] req_data, rsp_data, vprog_code, vout_meas, vset_out, rd, b;
  logic [`PSCC_C_WIDTH-1:0] fault_cond;
  logic [7:0] lk [2] = '{8'h80, 8'h40};
  int miscompares = 0;
  int tests_run = 0;
  int nvm_cnt = 0;
  pscc_host_model u_pscc_host_model (.link_clk(link_clk), .req_valid(req_valid),
    .req_write(req_write), .req_code(req_code), .req_data(req_data),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  pscc_handler u_pscc_handler (.ref_clk(ref_clk), .sys_rst(sys_rst), .link_clk(link_clk),
    .req_valid(req_valid), .req_write(req_write), .req_code(req_code),
    .req_data(req_data), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .remote_on(remote_on), .fault_cond(fault_cond),
    .vprog_code(vprog_code), .vout_meas(vout_meas), .pwr_en(pwr_en),
    .vset_out(vset_out), .alert_o(alert_o), .alert_oe_n(alert_oe_n),
    .nvm_store(nvm_store), .nvm_data(nvm_data));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Store pulse lasts one cycle, so catch it here
  always @(posedge ref_clk) begin
    if (nvm_store === 1'b1) begin
      nvm_cnt <= nvm_cnt + 1;
      nvm_last <= nvm_data;
    end
  end
  task automatic report_and_stop();
    if (miscompares == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic settle();
    repeat (10) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    u_pscc_host_model.xfer(1'b1, c, d, rd);
    settle();
  endtask
  task automatic rdc(input logic [7:0] c, input logic [15:0] m, input logic [15:0] exp,
                     input string name);
    u_pscc_host_model.xfer(1'b0, c, 16'h0000, rd);
    chk(name, rd & m, exp);
  endtask
  task automatic setf(input logic [`PSCC_C_WIDTH-1:0] v, input logic r);
    @(posedge ref_clk);
    #1;
    fault_cond = v;
    remote_on = r;
    settle();
  endtask
  task automatic do_reset();
    @(posedge ref_clk);
    #1;
    sys_rst = 1'b1;
    // Counted on the slow clock so the link side sees it too
    repeat (8) @(posedge link_clk);
    @(posedge ref_clk);
    #1;
    sys_rst = 1'b0;
    settle();
  endtask
  initial begin
    #300us;
    miscompares++;
    report_and_stop();
  end
  initial begin
    sys_rst = 1'b1;
    remote_on = 1'b1;
    fault_cond = '0;
    vprog_code = 16'h0a5a;
    vout_meas = 16'h0000;
    do_reset();
    chk("pwr_en reset", pwr_en, 16'h0001);
    chk("vset reset", vset_out, 16'h0a5a);
    chk("alert idle", alert_oe_n, 16'h0001);
    chk("alert level", alert_o, 16'h0000);
    rdc(`PSCC_CMD_WRITE_LOCK, 16'hffff, 16'h0080, "lock reset");
    rdc(`PSCC_CMD_OC_REACT, 16'hffff, 16'h00f8, "oc react");
    rdc(`PSCC_CMD_OT_REACT, 16'hffff, 16'h00f8, "ot react");
    foreach (lk[i]) begin
      wr(`PSCC_CMD_WRITE_LOCK, {8'h00, lk[i]});
      rdc(`PSCC_CMD_WRITE_LOCK, 16'hffff, {8'h00, lk[i]}, "lock value");
      wr(`PSCC_CMD_VOUT_SET, 16'h1234);
      chk("vset locked", vset_out, 16'h0a5a);
      rdc(`PSCC_CMD_SUM_BYTE, 16'h00fe, 16'h0002, "comm flag");
      chk("alert comm", alert_oe_n, 16'h0000);
      wr(`PSCC_CMD_CLEAR_FAULTS, 16'h0000);
      rdc(`PSCC_CMD_SUM_BYTE, 16'h0002, 16'h0002, "clear locked");
    end
    wr(`PSCC_CMD_WRITE_LOCK, 16'h0000);
    wr(`PSCC_CMD_CLEAR_FAULTS, 16'h0000);
    rdc(`PSCC_CMD_SUM_BYTE, 16'hffff, 16'h0000, "cleared");
    chk("alert released", alert_oe_n, 16'h0001);
    rdc(`PSCC_CMD_MAKER_STAT, 16'hffff, 16'h0000, "maker cleared");
    wr(8'h11, 16'h0000);
    chk("nvm pulses", 16'(nvm_cnt), 16'h0001);
    chk("nvm value", nvm_last, 16'h0000);
    wr(`PSCC_CMD_ON_OFF, 16'h0000);
    chk("pwr_en off", pwr_en, 16'h0000);
    rdc(`PSCC_CMD_SUM_BYTE, 16'h0040, 16'h0040, "byte off");
    rdc(`PSCC_CMD_SUM_WORD, 16'h0840, 16'h0840, "word off");
    wr(`PSCC_CMD_ON_OFF, 16'h0080);
    chk("pwr_en on", pwr_en, 16'h0001);
    rdc(8'h99, 16'hffff, 16'h0000, "unsupported");
    rdc(`PSCC_CMD_SUM_BYTE, 16'h0002, 16'h0002, "comm unsup");
    u_pscc_host_model.off_on();
    settle();
    rdc(`PSCC_CMD_SUM_BYTE, 16'hffff, 16'h0000, "restart");
    chk("alert restart", alert_oe_n, 16'h0001);
    wr(`PSCC_CMD_OV_WARN_LVL, 16'h1000);
    vout_meas = 16'h1000;
    settle();
    rdc(`PSCC_CMD_VOUT_STAT, 16'hffff, 16'h0000, "ov warn at");
    vout_meas = 16'h1001;
    setf(17'h0_7fff, 1'b1);
    rdc(`PSCC_CMD_VOUT_STAT, 16'hffff, 16'h00f0, "vout stat");
    rdc(`PSCC_CMD_IOUT_STAT, 16'hffff, 16'h00a0, "iout stat");
    rdc(`PSCC_CMD_INPUT_STAT, 16'hffff, 16'h00f0, "input stat");
    rdc(`PSCC_CMD_TEMP_STAT, 16'hffff, 16'h00c0, "temp stat");
    rdc(`PSCC_CMD_FAN_STAT, 16'hffff, 16'h00cc, "fan stat");
    rdc(`PSCC_CMD_SUM_BYTE, 16'h007c, 16'h007c, "byte faults");
    b = rd;
    rdc(`PSCC_CMD_SUM_WORD, 16'hec00, 16'hec00, "word faults");
    chk("word low", rd & 16'h00ff, b);
    chk("hiccup off", pwr_en, 16'h0000);
    wr(`PSCC_CMD_CLEAR_FAULTS, 16'h0000);
    rdc(`PSCC_CMD_IOUT_STAT, 16'hffff, 16'h00a0, "persist");
    chk("alert again", alert_oe_n, 16'h0000);
    vout_meas = 16'h0000;
    setf('0, 1'b1);
    chk("hiccup back", pwr_en, 16'h0001);
    wr(`PSCC_CMD_OC_REACT, 16'h00c0);
    rdc(`PSCC_CMD_OC_REACT, 16'hffff, 16'h00c0, "oc latch");
    rdc(`PSCC_CMD_OT_REACT, 16'hffff, 16'h00f8, "ot alone");
    setf(17'h0_0008, 1'b1);
    setf('0, 1'b1);
    chk("latched off", pwr_en, 16'h0000);
    setf('0, 1'b0);
    setf('0, 1'b1);
    chk("latch freed", pwr_en, 16'h0001);
    wr(`PSCC_CMD_OT_REACT, 16'h0055);
    rdc(`PSCC_CMD_OT_REACT, 16'hffff, 16'h00f8, "bad react");
    rdc(`PSCC_CMD_SUM_BYTE, 16'h0002, 16'h0002, "comm react");
    wr(`PSCC_CMD_VOUT_SET, 16'h1234);
    chk("vset bus", vset_out, 16'h1234);
    vprog_code = 16'h0bbb;
    settle();
    chk("vset pin ignored", vset_out, 16'h1234);
    do_reset();
    chk("vset pin again", vset_out, 16'h0bbb);
    report_and_stop();
  end
endmodule // pscc_handler_tb_top
`default_nettype wire
